// *** lsfh_ctrl.v ***
// LED string fault handling and headroom optimizer control.
// Assumes all inputs synchronous to clock; register port is a simple
// byte-wide access strobe decoded by the serial interface logic outside.
`timescale 1ns/1ns
`include "lsfh_defs.vh"
module lsfh_ctrl #(
    parameter        HAS_STRAP  = 1,                         // 0 = variant without strap
    parameter [31:0] SETTLE_CYC = `LSFH_SETTLE_CYC,          // 4 ms settle
    parameter [31:0] RECAL_CYC  = `LSFH_RECAL_CYC            // 1 s recalibration
) (
    input  wire       clock,              // 250 MHz clock
    input  wire       rst,                // Power-up reset, active high
    input  wire       enable,             // Device enable level
    input  wire       supplyInputOk,      // Supply present
    input  wire [1:0] shortLimitSelect,   // Strap level code
    input  wire [7:0] stringSinking,      // String currently sinking
    input  wire [7:0] stringOverLimit,    // Per-level compare result, valid for thrLevel
    input  wire [7:0] stringLossRaw,      // Raw regulation loss
    input  wire       boostOverVolt,      // Boost over-voltage comparator
    input  wire       regWrite,           // Register write strobe
    input  wire       regRead,            // Register read strobe
    input  wire [7:0] regAddr,            // Register address
    input  wire [7:0] regWdata,           // Register write data
    output reg  [7:0] regRdata,           // Register read data
    output reg  [7:0] thrLevel,           // Active short threshold code
    output reg  [7:0] injectCode,         // Feedback injection code
    output reg  [7:0] stringEnable,       // String enabled
    output reg        faultOutNOe,        // Fault pin pulled low when high
    output reg        calBusy             // Calibration running
);
    localparam ST_OFF    = 3'h0;
    localparam ST_STEPUP = 3'h1;
    localparam ST_SETTLE = 3'h2;
    localparam ST_STEPDN = 3'h3;
    localparam ST_RUN    = 3'h4;
    localparam ST_RAISE  = 3'h5;

    reg  [2:0]  state_reg;
    reg  [31:0] timer_reg;
    reg  [31:0] recal_reg;
    reg  [7:0]  shortFlag_reg;
    reg  [7:0]  openFlag_reg;
    reg         enPrev_reg;
    reg         turnedOn_reg;
    reg         strapPend_reg;
    wire [7:0]  lossSeen;
    wire [7:0]  lossMon;
    wire [7:0]  newShort;
    wire        anyLoss;
    wire        enRise;
    wire        active;
    wire        settled;
    wire        atMax;
    wire [7:0]  openSet;
    reg         recalReq;

    lsfh_reg_loss_filter u_filter (
        .clock    (clock),
        .rst      (rst),
        .lossRaw  (stringLossRaw),
        .lossSeen (lossSeen)
    );

    assign active   = enable && supplyInputOk;
    assign enRise   = enable && !enPrev_reg;
    assign lossMon  = lossSeen & stringEnable;
    assign anyLoss  = |lossMon;
    assign newShort = stringSinking & stringOverLimit & stringEnable;
    assign settled  = (timer_reg == 32'h0000_0000);
    // Lowest code is the highest boost voltage
    assign atMax    = (injectCode == `LSFH_CODE_MIN);
    // Open strings found this cycle; fault pin follows in the same edge as the flag
    assign openSet  = (state_reg == ST_RAISE && atMax && settled) ? lossMon : 8'h00;

    // Threshold register and strap capture
    always @(posedge clock) begin
        if (rst) begin
            thrLevel      <= `LSFH_THR_6V8;
            strapPend_reg <= 1'b1;
            enPrev_reg    <= 1'b0;
        end else begin
            enPrev_reg <= enable;
            if (!HAS_STRAP) begin
                if (strapPend_reg || enRise) begin
                    thrLevel <= `LSFH_THR_6V8;
                end
                strapPend_reg <= 1'b0;
            end else if (strapPend_reg || enRise) begin
                // Strap read after reset release, never under reset
                thrLevel      <= {6'h00, shortLimitSelect};
                strapPend_reg <= 1'b0;
            end else if (regWrite && regAddr == `LSFH_ADDR_THRESH) begin
                thrLevel <= {6'h00, regWdata[1:0]};
            end
        end
    end

    // Register reads: both fault kinds live in the flag range
    always @(posedge clock) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `LSFH_ADDR_THRESH:  regRdata <= thrLevel;
                `LSFH_ADDR_FLAGS_A: regRdata <= shortFlag_reg;
                `LSFH_ADDR_FLAGS_B: regRdata <= openFlag_reg;
                `LSFH_ADDR_FLAGS_C: regRdata <= shortFlag_reg | openFlag_reg;
                `LSFH_ADDR_FLAGS_D: regRdata <= ~stringEnable;
                default:            regRdata <= 8'h00;
            endcase
        end
    end

    // Recalibration timer
    always @(posedge clock) begin
        if (rst || !active || state_reg != ST_RUN) begin
            recal_reg <= RECAL_CYC - 32'h1;
            recalReq  <= 1'b0;
        end else if (recal_reg == 32'h0000_0000) begin
            recal_reg <= RECAL_CYC - 32'h1;
            recalReq  <= 1'b1;
        end else begin
            recal_reg <= recal_reg - 32'h1;
            recalReq  <= 1'b0;
        end
    end

    // Fault latches, string enables and fault pin
    always @(posedge clock) begin
        if (rst || !enable) begin
            // Enable low clears latches and fault pin and re-arms all strings
            shortFlag_reg <= 8'h00;
            openFlag_reg  <= 8'h00;
            stringEnable  <= 8'hff;
            faultOutNOe   <= 1'b0;
        end else begin
            shortFlag_reg <= shortFlag_reg | newShort;
            if (state_reg == ST_RAISE && atMax && settled) begin
                openFlag_reg <= openFlag_reg | lossMon;
                stringEnable <= stringEnable & ~newShort & ~lossMon;
            end else begin
                stringEnable <= stringEnable & ~newShort;
            end
            faultOutNOe <= (|shortFlag_reg) || (|openFlag_reg) ||
                           (|newShort) || (|openSet) || boostOverVolt;
        end
    end

    // Headroom optimizer
    always @(posedge clock) begin
        if (rst || !active) begin
            state_reg    <= ST_OFF;
            injectCode   <= `LSFH_CODE_MIN;
            timer_reg    <= 32'h0000_0000;
            calBusy      <= 1'b0;
            turnedOn_reg <= 1'b0;
        end else begin
            if (!settled) begin
                timer_reg <= timer_reg - 32'h1;
            end
            case (state_reg)
                ST_OFF: begin
                    turnedOn_reg <= 1'b1;
                    calBusy      <= 1'b1;
                    timer_reg    <= SETTLE_CYC - 32'h1;
                    state_reg    <= ST_SETTLE;
                end
                ST_STEPUP: begin
                    if (injectCode != `LSFH_CODE_MAX) begin
                        injectCode <= injectCode + 8'h01;
                        timer_reg  <= SETTLE_CYC - 32'h1;
                        state_reg  <= ST_SETTLE;
                    end else begin
                        calBusy   <= 1'b0;
                        state_reg <= ST_RUN;
                    end
                end
                ST_SETTLE: begin
                    if (settled) begin
                        state_reg <= anyLoss ? ST_STEPDN : ST_STEPUP;
                    end
                end
                ST_STEPDN: begin
                    if (!atMax) begin
                        injectCode <= injectCode - 8'h01;
                    end
                    calBusy   <= 1'b0;
                    timer_reg <= SETTLE_CYC - 32'h1;
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (anyLoss && settled) begin
                        state_reg <= ST_RAISE;
                    end else if (recalReq) begin
                        calBusy   <= 1'b1;
                        timer_reg <= SETTLE_CYC - 32'h1;
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_RAISE: begin
                    if (!anyLoss) begin
                        state_reg <= ST_RUN;
                    end else if (settled) begin
                        if (!atMax) begin
                            injectCode <= injectCode - 8'h01;
                            timer_reg  <= SETTLE_CYC - 32'h1;
                        end else begin
                            calBusy   <= 1'b1;
                            timer_reg <= SETTLE_CYC - 32'h1;
                            state_reg <= ST_SETTLE;
                        end
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
            if (|newShort) begin
                calBusy   <= 1'b1;
                timer_reg <= SETTLE_CYC - 32'h1;
                state_reg <= ST_SETTLE;
            end
        end
    end
endmodule

// *** lsfh_defs.vh ***
// Constants for the LED string fault and headroom controller.
// Included by the design files; definitions only.
`ifndef LSFH_DEFS_VH
`define LSFH_DEFS_VH

`define LSFH_NSTR            8
`define LSFH_ADDR_THRESH     8'h04
`define LSFH_ADDR_FLAGS_A    8'h05
`define LSFH_ADDR_FLAGS_B    8'h06
`define LSFH_ADDR_FLAGS_C    8'h07
`define LSFH_ADDR_FLAGS_D    8'h08
`define LSFH_THR_4V9         8'h00
`define LSFH_THR_5V8         8'h01
`define LSFH_THR_6V8         8'h02
`define LSFH_THR_7V6         8'h03
`define LSFH_CLK_MHZ         250
`define LSFH_LOSS_NS         2000
`define LSFH_LOSS_CYC        ((`LSFH_LOSS_NS * `LSFH_CLK_MHZ) / 1000 + 1)
`define LSFH_SETTLE_US       4000
`define LSFH_SETTLE_CYC      (`LSFH_SETTLE_US * `LSFH_CLK_MHZ)
`define LSFH_RECAL_MS        1000
`define LSFH_RECAL_CYC       (`LSFH_RECAL_MS * 1000 * `LSFH_CLK_MHZ)
`define LSFH_CODE_MAX        8'hff
`define LSFH_CODE_MIN        8'h00

`endif

// *** lsfh_reg_loss_filter.v ***
// Per-string persistence filter on loss of current regulation.
// Assumes loss inputs are synchronous to clock.
`timescale 1ns/1ns
`include "lsfh_defs.vh"
module lsfh_reg_loss_filter (
    input  wire       clock,      // System clock
    input  wire       rst,        // Synchronous reset
    input  wire [7:0] lossRaw,    // Raw loss of regulation per string
    output wire [7:0] lossSeen    // Loss held past persistence time
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_str
            reg [9:0] cnt_reg;
            reg       seen_reg;
            always @(posedge clock) begin
                if (rst || !lossRaw[i]) begin
                    cnt_reg  <= 10'h000;
                    seen_reg <= 1'b0;
                end else if ({22'h000000, cnt_reg} == `LSFH_LOSS_CYC - 1) begin
                    seen_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 10'h001;
                end
            end
            assign lossSeen[i] = seen_reg;
        end
    endgenerate
endmodule

// *** lsfh_ctrl_assertions.sv ***
// Checker for the string fault and headroom controller.
// Sees only controller ports; bound into every lsfh_ctrl instance.
`timescale 1ns/1ns
module lsfh_ctrl_assertions #(
    parameter HAS_STRAP = 1 // Strap present
) (
    input wire       clock,            // Clock
    input wire       rst,              // Reset
    input wire       enable,           // Enable
    input wire [1:0] shortLimitSelect, // Strap
    input wire [7:0] stringSinking,    // Sinking
    input wire [7:0] stringOverLimit,  // Over limit
    input wire       boostOverVolt,    // Over-voltage
    input wire       regWrite,         // Write strobe
    input wire [7:0] regAddr,          // Address
    input wire [7:0] regWdata,         // Write data
    input wire [7:0] thrLevel,         // Threshold
    input wire [7:0] injectCode,       // Code
    input wire [7:0] stringEnable,     // Enables
    input wire       faultOutNOe,      // Fault drive
    input wire       calBusy           // Calibrating
);
    wire [7:0] newShort = stringSinking & stringOverLimit & stringEnable;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ov_pull_low_a: assert property (enable && boostOverVolt ##1 enable |-> faultOutNOe)
        else $error("Over-voltage did not pull the fault output");
    short_react_a: assert property (enable && |newShort ##1 enable |->
        faultOutNOe && calBusy && !(|(stringEnable & $past(newShort))))
        else $error("Short not acted on");
    fault_hold_a: assert property (faultOutNOe && enable && !(&stringEnable) ##1 enable
        |-> faultOutNOe)
        else $error("Latched fault released");
    clear_low_a: assert property (!enable |=> stringEnable == 8'hff)
        else $error("Strings not restored while enable low");
    code_sat_a: assert property (enable && injectCode == 8'hff ##1 enable |-> injectCode != 8'h00)
        else $error("Code wrapped at top");
    code_step_a: assert property (enable && $past(enable) && $past(enable, 2) && $changed(injectCode)
        |-> (injectCode - $past(injectCode) == 8'h01) || ($past(injectCode) - injectCode == 8'h01))
        else $error("Code moved by more than one step");
    thr_write_a: assert property (regWrite && regAddr == 8'h04 && enable && $past(enable)
        && !$past(rst) |=> thrLevel[1:0] == $past(regWdata[1:0]))
        else $error("Threshold write lost");
    strap_cap_a: assert property (HAS_STRAP != 0 && $rose(enable)
        |-> ##[1:2] thrLevel[1:0] == shortLimitSelect)
        else $error("Strap not captured on enable rise");
    cover property (enable && |newShort);
    cover property (enable && boostOverVolt);
    cover property ($fell(calBusy));
endmodule
bind lsfh_ctrl lsfh_ctrl_assertions #(.HAS_STRAP(HAS_STRAP)) i_lsfh_ctrl_assertions (
    .clock, .rst, .enable, .shortLimitSelect, .stringSinking, .stringOverLimit, .boostOverVolt,
    .regWrite, .regAddr, .regWdata, .thrLevel, .injectCode, .stringEnable, .faultOutNOe, .calBusy
);

// *** lsfh_led_model.sv ***
// Far-side model: eight LED strings and the boost feedback node.
// Assumes the bench injects string faults off the rising edge.
`timescale 1ns/1ns
module lsfh_led_model #(
    parameter [7:0] LIMIT = 8'h03 // Highest code that keeps headroom
) (
    input  wire       clock,           // Clock
    input  wire [7:0] injectCode,      // Optimizer code
    input  wire [7:0] stringSinking,   // Strings on
    input  wire [7:0] shortStr,        // Shorted LEDs
    input  wire [7:0] openStr,         // Open strings
    output reg  [7:0] stringOverLimit, // Sink above threshold
    output reg  [7:0] stringLossRaw    // Regulation lost
);
    initial stringOverLimit = 8'h00;
    initial stringLossRaw = 8'h00;
    always @(negedge clock) begin
        stringOverLimit <= shortStr & stringSinking;
        // Higher code lowers the anode voltage; an open string never regulates
        stringLossRaw <= stringSinking & (openStr | {8{injectCode > LIMIT}});
    end
endmodule

// *** lsfh_ctrl_test.sv ***
// Self-checking bench for the string fault and headroom controller.
// Assumes the LED string model on the far side; short counts for speed.
`timescale 1ns/1ns
module lsfh_ctrl_test;
    reg        clock = 1'b0;
    reg        rst = 1'b1;
    reg        enable = 1'b1;
    reg        supplyInputOk = 1'b1;
    reg [1:0]  shortLimitSelect = 2'h1;
    reg [7:0]  stringSinking = 8'hff;
    reg        boostOverVolt = 1'b0;
    reg        regWrite = 1'b0;
    reg        regRead = 1'b0;
    reg [7:0]  regAddr = 8'h00;
    reg [7:0]  regWdata = 8'h00;
    reg [7:0]  shortStr = 8'h00;
    reg [7:0]  openStr = 8'h00;
    wire [7:0] stringOverLimit, stringLossRaw, regRdata, thrLevel, injectCode, stringEnable;
    wire       faultOutNOe, calBusy;
    integer    nErrors = 0;
    integer    checksDone = 0;
    integer    cycles = 0;
    integer    s;
    lsfh_ctrl #(.HAS_STRAP(1), .SETTLE_CYC(32'd600), .RECAL_CYC(32'd30000)) i_lsfh_ctrl (
        .clock(clock), .rst(rst), .enable(enable), .supplyInputOk(supplyInputOk),
        .shortLimitSelect(shortLimitSelect), .stringSinking(stringSinking),
        .stringOverLimit(stringOverLimit), .stringLossRaw(stringLossRaw),
        .boostOverVolt(boostOverVolt), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .thrLevel(thrLevel),
        .injectCode(injectCode), .stringEnable(stringEnable), .faultOutNOe(faultOutNOe),
        .calBusy(calBusy));
    lsfh_led_model #(.LIMIT(8'h03)) i_lsfh_led_model (.clock(clock), .injectCode(injectCode),
        .stringSinking(stringSinking), .shortStr(shortStr), .openStr(openStr),
        .stringOverLimit(stringOverLimit), .stringLossRaw(stringLossRaw));
    initial begin
        forever #2 clock = ~clock;
    end
    task printVerdict;
        begin
            if (nErrors == 0 && checksDone > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] expected, input string what);
        begin
            checksDone = checksDone + 1;
            if (seen !== expected) begin
                nErrors = nErrors + 1;
                $display("Error %s expected %h seen %h", what, expected, seen);
            end
        end
    endtask
    task waitCyc(input integer n);
        begin
            repeat (n) @(negedge clock);
        end
    endtask
    task regAccess(input rd, input [7:0] addr, input [7:0] data, input string what);
        begin
            @(negedge clock);
            regAddr = addr;
            regWdata = data;
            regRead = rd;
            regWrite = !rd;
            @(negedge clock);
            regRead = 1'b0;
            regWrite = 1'b0;
            if (rd)
                check(regRdata, data, what);
        end
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 50000) begin
            nErrors = nErrors + 1;
            printVerdict;
        end
    end
    initial begin
        waitCyc(20);
        rst = 1'b0;
        waitCyc(3);
        check(stringEnable, 8'hff, "enables");
        check(thrLevel, 8'h01, "strap");
        regAccess(1'b0, 8'h04, 8'h03, "");
        regAccess(1'b1, 8'h04, 8'h03, "threshold");
        regAccess(1'b0, 8'h05, 8'hff, "");
        regAccess(1'b1, 8'h05, 8'h00, "flags");
        regAccess(1'b1, 8'h20, 8'h00, "unmapped");
        for (s = 0; s < 4; s = s + 1) begin
            enable = 1'b0;
            waitCyc(2);
            shortLimitSelect = s[1:0];
            enable = 1'b1;
            waitCyc(3);
            check(thrLevel, s[7:0], "strap level");
        end
        supplyInputOk = 1'b0;
        waitCyc(2);
        check(calBusy, 8'h00, "supply off");
        supplyInputOk = 1'b1;
        waitCyc(3);
        check(calBusy, 8'h01, "cal start");
        waitCyc(3600);
        check(injectCode, 8'h03, "cal code");
        openStr = 8'h01;
        waitCyc(400);
        openStr = 8'h00;
        waitCyc(700);
        check(injectCode, 8'h03, "brief loss");
        shortStr = 8'h04;
        waitCyc(3);
        check(stringEnable, 8'hfb, "short off");
        check(calBusy, 8'h01, "short recal");
        shortStr = 8'h00;
        regAccess(1'b1, 8'h05, 8'h04, "short flags");
        regAccess(1'b1, 8'h08, 8'h04, "disabled");
        check(faultOutNOe, 8'h01, "fault held");
        enable = 1'b0;
        waitCyc(2);
        enable = 1'b1;
        waitCyc(3);
        check(stringEnable, 8'hff, "cleared");
        check(faultOutNOe, 8'h00, "fault clear");
        boostOverVolt = 1'b1;
        waitCyc(2);
        check(faultOutNOe, 8'h01, "ov fault");
        boostOverVolt = 1'b0;
        waitCyc(2);
        check(faultOutNOe, 8'h00, "ov release");
        waitCyc(3600);
        openStr = 8'h20;
        for (s = 0; s < 4000 && stringEnable[5] !== 1'b0; s = s + 1)
            waitCyc(1);
        check(injectCode, 8'h00, "max boost");
        check(stringEnable, 8'hdf, "open off");
        check(faultOutNOe, 8'h01, "open fault");
        regAccess(1'b1, 8'h06, 8'h20, "open flags");
        for (s = 0; s < 5000 && calBusy !== 1'b0; s = s + 1)
            waitCyc(1);
        for (s = 0; s < 31000 && calBusy !== 1'b1; s = s + 1)
            waitCyc(1);
        check(calBusy, 8'h01, "periodic recal");
        printVerdict;
    end
endmodule
